/* File: tb/fbcd_flash_model.sv */
// Purpose: Behavioural two-bank flash seen by the host controller bench
// Assumes: Bank is address bit 20; event driven, no clock of its own
// Notes:   Released data pins show the inverse of the last word driven
`timescale 1ns/1ns
`default_nettype none
module fbcd_flash_model #(
  parameter logic [7:0] MAKER = 8'h3c,  // Arbitrary maker code
  parameter logic [7:0] DEVID = 8'h7e   // Arbitrary device code
) (
  input  wire fbcd_pkg::fbcd_pins_type pins,
  input  wire logic                    rst_n,
  input  wire logic                    byte_mode,
  input  wire logic [1:0]              busy,
  input  wire logic                    corrupt,
  output logic [15:0]                  dq,
  output var int                       reset_writes
);
  // Extended query words 40h..4Fh; 4Ah and 4Fh hold variant values
  localparam logic [7:0] QT [16] = '{8'h50, 8'h52, 8'h49, 8'h31, 8'h33, 8'h04, 8'h02,
    8'h01, 8'h01, 8'h04, 8'h20, 8'h00, 8'h00, 8'h85, 8'h95, 8'h02};
  logic [1:0]  id_m  = 2'b00;
  logic [1:0]  qr_m  = 2'b00;
  logic        sec_m = 1'b0;
  logic        wr_on = 1'b0;
  logic [1:0]  step  = 2'd0;
  logic [20:0] wa    = 21'h0;
  logic [15:0] v;
  logic [15:0] last  = 16'h0000;
  wire logic [7:0]  d  = pins.dq_o[7:0];
  wire logic [10:0] lo = wa[10:0];
  initial reset_writes = 0;

  // Address taken on whichever strobe falls later
  always @(negedge pins.we_n or negedge pins.ce_n) begin
    if (!pins.we_n && !pins.ce_n) begin
      wa = pins.addr;
      wr_on = 1'b1;
    end
  end

  // Data taken on the earlier strobe rise; a broken sequence just falls back to idle
  always @(posedge pins.we_n or posedge pins.ce_n or negedge rst_n) begin
    if (!rst_n) begin
      {id_m, qr_m, sec_m, step} = '0;
    end else if (wr_on) begin
      wr_on = 1'b0;
      if (d == fbcd_pkg::CMD_RESET) begin
        {id_m, qr_m, step} = '0;
        reset_writes++;
      end else if (d == fbcd_pkg::CMD_QUERY && lo == fbcd_pkg::QUERY_ADDR)
        qr_m[wa[20]] = 1'b1;
      else if (step == 0 && d == fbcd_pkg::UNLOCK1_DATA && lo == fbcd_pkg::UNLOCK1_ADDR)
        step = 2'd1;
      else if (step == 1 && d == fbcd_pkg::UNLOCK2_DATA && lo == fbcd_pkg::UNLOCK2_ADDR)
        step = 2'd2;
      else if (step == 2 && d == fbcd_pkg::CMD_IDENT && !sec_m)
        {id_m[wa[20]], step} = 3'b100;
      else if (step == 2 && d == fbcd_pkg::CMD_IDENT)
        step = 2'd3;
      else if (step == 2 && d == fbcd_pkg::CMD_SEC_ENTER)
        {sec_m, step} = 3'b100;
      else if (step == 3 && d == fbcd_pkg::CMD_SEC_EXIT2)
        {sec_m, step} = 3'b000;
      else
        step = 2'd0;
    end
  end

  // Read data by the mode of the addressed bank, except secured mode which covers both banks
  always @* begin
    if (sec_m)
      v = ~pins.addr[15:0];
    else if (busy[pins.addr[20]])
      v = 16'h0020;
    else if (qr_m[pins.addr[20]] && pins.addr[7:4] == 4'h4)
      v = {8'h00, (corrupt && pins.addr[3:0] == 4'h3) ? 8'h32 : QT[pins.addr[3:0]]};
    else if (id_m[pins.addr[20]] && pins.addr[7:0] < 8'h02)
      v = {8'h00, pins.addr[0] ? DEVID : MAKER};
    else if (id_m[pins.addr[20]])
      v = {15'h0, pins.addr[12]};
    else
      v = pins.addr[15:0] ^ 16'h5a5a;
    if (byte_mode)
      v[15:8] = 8'h00;
    dq = (pins.ce_n || pins.oe_n) ? ~last : v;
  end

  // Remember the last word so a released bus never repeats it
  always @(posedge pins.oe_n) last = v;
endmodule
`default_nettype wire

/* File: tb/fbcd_host_bench.sv */
// Purpose: Self-checking bench for the host flash command controller
// Assumes: Flash model on the far side, 100 MHz clock
// Notes:   Ops go one at a time through run_op
`timescale 1ns/1ns
`default_nettype none
module fbcd_host_bench;
  localparam logic [7:0] MAKER = 8'h3c;  // Arbitrary
  localparam logic [7:0] DEVID = 8'h7e;  // Arbitrary
  logic                    sys_clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, cmd_bank = 1'b0;
  logic                    byte_mode = 1'b0, corrupt = 1'b0;
  logic [1:0]              cmd_sel = 2'h0, bank_busy = 2'h0, bank_ident;
  logic [20:0]             cmd_addr = 21'h0;
  fbcd_pkg::fbcd_op_type   cmd_op = fbcd_pkg::OP_READ;
  fbcd_pkg::fbcd_pins_type flash_pins;
  logic [15:0]             flash_dq_i, rsp_data;
  logic                    flash_rst_n, cmd_ready, rsp_valid, rsp_err, secured_mode, query_fail;
  int                      miscompares = 0, tests_run = 0, reset_writes, rw0;

  // Free running clock
  always #5 sys_clk = ~sys_clk;

  fbcd_host dut (.sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_bank(cmd_bank), .cmd_addr(cmd_addr), .cmd_sel(cmd_sel), .byte_mode(byte_mode),
    .bank_busy(bank_busy), .flash_dq_i(flash_dq_i), .flash_pins(flash_pins),
    .flash_rst_n(flash_rst_n), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_err(rsp_err), .rsp_data(rsp_data), .bank_ident(bank_ident),
    .secured_mode(secured_mode), .query_fail(query_fail));
  fbcd_flash_model #(.MAKER(MAKER), .DEVID(DEVID)) model (.pins(flash_pins),
    .rst_n(flash_rst_n), .byte_mode(byte_mode), .busy(bank_busy), .corrupt(corrupt),
    .dq(flash_dq_i), .reset_writes(reset_writes));

  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d miscompares", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // Byte mode hands back only the low byte
  function automatic logic [15:0] bx(input logic [15:0] x);
    bx = byte_mode ? {8'h00, x[7:0]} : x;
  endfunction

  // Issue one op, hold it until taken, then wait a bounded time for the answer
  task automatic run_op(input fbcd_pkg::fbcd_op_type op, input logic bk,
                        input logic [20:0] a, input logic [1:0] s);
    int n;
    n = 0;
    @(posedge sys_clk);
    #1;
    {cmd_valid, cmd_op, cmd_bank, cmd_addr, cmd_sel} = {1'b1, op, bk, a, s};
    while (cmd_ready !== 1'b1) @(posedge sys_clk) #1;
    @(posedge sys_clk);
    #1 cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1 n++;
    end
    if (n == 400) begin
      miscompares++;
      report_and_stop();
    end
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    #1 nrst = 1'b1;
    check(cmd_ready, 1'b1);
    run_op(fbcd_pkg::OP_READ, 1'b0, 21'h001234, 2'd0);
    check(rsp_data, 16'h1234 ^ 16'h5a5a);
    $display("test power-up read done");
    for (int bm = 0; bm < 2; bm++) begin
      byte_mode = bm[0];
      run_op(fbcd_pkg::OP_IDENT, 1'b0, 21'h000000, 2'd0);
      check(bank_ident, 2'b01);
      for (int s = 0; s < 3; s++) begin
        run_op(fbcd_pkg::OP_ID_READ, 1'b0, 21'h001000, s[1:0]);
        check(rsp_data, s == 0 ? {8'h00, MAKER} : s == 1 ? {8'h00, DEVID} : 16'h1);
      end
      run_op(fbcd_pkg::OP_READ, 1'b1, 21'h100055, 2'd0);
      check(rsp_data, bx(16'h0055 ^ 16'h5a5a));
      run_op(fbcd_pkg::OP_RESET, 1'b0, 21'h1fffff, 2'd0);
      check(bank_ident, 2'b00);
      run_op(fbcd_pkg::OP_READ, 1'b0, 21'h000002, 2'd0);
      check(rsp_data, bx(16'h0002 ^ 16'h5a5a));
      run_op(fbcd_pkg::OP_QUERY_CHECK, 1'b0, 21'h000000, 2'd0);
      check({rsp_err, query_fail}, 2'b00);
      check(rsp_data, 16'h0002);
      $display("test identify and query pass done");
    end
    byte_mode = 1'b0;
    corrupt = 1'b1;
    run_op(fbcd_pkg::OP_QUERY_CHECK, 1'b0, 21'h000000, 2'd0);
    check(query_fail, 1'b1);
    corrupt = 1'b0;
    bank_busy = 2'b10;
    run_op(fbcd_pkg::OP_IDENT, 1'b0, 21'h000000, 2'd0);
    check({rsp_err, bank_ident}, 3'b100);
    rw0 = reset_writes;
    run_op(fbcd_pkg::OP_READ, 1'b1, 21'h100000, 2'd0);
    check(rsp_data, 16'h0020);
    check(16'(reset_writes - rw0), 16'h1);
    bank_busy = 2'b00;
    $display("test refusal and timing flag done");
    run_op(fbcd_pkg::OP_SEC_ENTER, 1'b0, 21'h000000, 2'd0);
    check(secured_mode, 1'b1);
    run_op(fbcd_pkg::OP_READ, 1'b0, 21'h000abc, 2'd0);
    check(rsp_data, ~16'h0abc);
    run_op(fbcd_pkg::OP_SEC_EXIT, 1'b0, 21'h000000, 2'd0);
    check(secured_mode, 1'b0);
    run_op(fbcd_pkg::OP_SEC_ENTER, 1'b0, 21'h000000, 2'd0);
    run_op(fbcd_pkg::OP_HW_RESET, 1'b0, 21'h000000, 2'd0);
    check(secured_mode, 1'b0);
    run_op(fbcd_pkg::OP_READ, 1'b0, 21'h000abc, 2'd0);
    check(rsp_data, 16'h0abc ^ 16'h5a5a);
    $display("test secured region done");
    report_and_stop();
  end

  // Watchdog well beyond the thousand or so cycles the tests need
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end
endmodule
`default_nettype wire

/* File: verilog/fbcd_cycle.sv */
// Purpose: Runs one asynchronous flash write or read cycle on the pins
// Assumes: Pins sampled synchronous to sys_clk; one request at a time
// Notes:   Address set up one cycle before the strobe falls, data held past its rise
`timescale 1ns/1ns
`default_nettype none

module fbcd_cycle (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   start,
  input  wire fbcd_pkg::fbcd_cyc_type req,
  input  wire logic                   byte_mode,
  input  wire logic [15:0]            dq_i,
  output var  fbcd_pkg::fbcd_pins_type pins,
  output logic [15:0]                 rd_data,
  output logic                        done
);

  typedef enum logic [3:0] {
    C_IDLE   = 4'b0001,
    C_SETUP  = 4'b0010,
    C_STROBE = 4'b0100,
    C_HOLD   = 4'b1000
  } fbcd_cst_type;

  fbcd_cst_type cst_q;
  logic [7:0]   cnt_q;
  logic         wr_q;

  // Pin sequencing; strobe only falls once the address has stood a full cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cst_q      <= C_IDLE;
      cnt_q      <= 8'h00;
      wr_q       <= 1'b0;
      pins.addr  <= 21'h000000;
      pins.a_m1  <= 1'b0;
      pins.dq_o  <= 16'h0000;
      pins.dq_oe <= 1'b0;
      pins.ce_n  <= 1'b1;
      pins.oe_n  <= 1'b1;
      pins.we_n  <= 1'b1;
      rd_data    <= 16'h0000;
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      case (cst_q)
        C_IDLE: begin
          if (start) begin
            pins.addr <= req.addr;
            pins.a_m1 <= req.a_m1;
            pins.dq_o <= {8'h00, req.data};
            pins.ce_n <= 1'b0;
            wr_q      <= req.wr;
            cst_q     <= C_SETUP;
          end
        end
        C_SETUP: begin
          if (wr_q) begin
            pins.we_n  <= 1'b0;
            pins.dq_oe <= 1'b1;
            cnt_q      <= fbcd_pkg::WP_CYC;
          end else begin
            pins.oe_n <= 1'b0;
            cnt_q     <= fbcd_pkg::RDA_CYC;
          end
          cst_q <= C_STROBE;
        end
        C_STROBE: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            if (wr_q) begin
              pins.we_n <= 1'b1;
            end else begin
              rd_data   <= byte_mode ? {8'h00, dq_i[7:0]} : dq_i;
              pins.oe_n <= 1'b1;
            end
            cst_q <= C_HOLD;
          end
        end
        C_HOLD: begin
          // Data released only a cycle after the strobe rose
          pins.dq_oe <= 1'b0;
          pins.ce_n  <= 1'b1;
          done       <= 1'b1;
          cst_q      <= C_IDLE;
        end
        default: cst_q <= C_IDLE;
      endcase
    end
  end

  property p_addr_stable_strobe;
    @(posedge sys_clk) disable iff (!nrst)
      (!pins.we_n && $past(!pins.we_n)) |-> $stable(pins.addr) && pins.dq_oe;
  endproperty
  a_addr_stable_strobe: assert property (p_addr_stable_strobe)
    else $error("Address or data moved while write strobe low");

  property p_data_past_rise;
    @(posedge sys_clk) disable iff (!nrst)
      $rose(pins.we_n) |-> pins.dq_oe && !pins.ce_n ##1 !pins.dq_oe;
  endproperty
  a_data_past_rise: assert property (p_data_past_rise)
    else $error("Data not held one cycle past strobe rise");

endmodule

`default_nettype wire

/* File: verilog/fbcd_host.sv */
// Purpose: Host controller issuing command sequences to a two-bank flash
// Assumes: User knows which bank is busy or erase suspended; one op at a time
// Notes:   Query check compares the extended table and ends with a reset write
`timescale 1ns/1ns
`default_nettype none

module fbcd_host (
  input  wire logic                    sys_clk,
  input  wire logic                    nrst,
  input  wire logic                    cmd_valid,
  input  wire fbcd_pkg::fbcd_op_type   cmd_op,
  input  wire logic                    cmd_bank,
  input  wire logic [20:0]             cmd_addr,
  input  wire logic [1:0]              cmd_sel,
  input  wire logic                    byte_mode,
  input  wire logic [1:0]              bank_busy,
  input  wire logic [15:0]             flash_dq_i,
  output var  fbcd_pkg::fbcd_pins_type flash_pins,
  output logic                         flash_rst_n,
  output logic                         cmd_ready,
  output logic                         rsp_valid,
  output logic                         rsp_err,
  output logic [15:0]                  rsp_data,
  output logic [1:0]                   bank_ident,
  output logic                         secured_mode,
  output logic                         query_fail
);

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0001,
    S_RUN   = 4'b0010,
    S_WAIT  = 4'b0100,
    S_HWRST = 4'b1000
  } fbcd_st_type;

  fbcd_st_type           state_q;
  fbcd_pkg::fbcd_op_type op_q;
  fbcd_pkg::fbcd_cyc_type req_q;
  logic [4:0]            step_q;
  logic [7:0]            cnt_q;
  logic [20:0]           addr_q;
  logic [1:0]            sel_q;
  logic                  bank_q;
  logic                  busy_q;
  logic                  start_q;
  logic                  cyc_done;
  logic [15:0]           cyc_rd;
  logic                  accept;
  logic                  refuse;
  logic                  last;
  logic                  fin;
  logic                  auto_rst;
  logic [3:0]            qidx;

  assign accept   = (state_q == S_IDLE) && cmd_valid && cmd_ready;
  // Identify and query only go to an idle bank while the other is idle too
  assign refuse   = ((cmd_op == fbcd_pkg::OP_IDENT) || (cmd_op == fbcd_pkg::OP_QUERY_CHECK))
                    && (bank_busy != 2'b00);
  assign last     = (step_q == seq_last(op_q));
  assign fin      = (state_q == S_WAIT) && cyc_done && last && !auto_rst;
  assign auto_rst = (op_q == fbcd_pkg::OP_READ) && busy_q
                    && cyc_rd[fbcd_pkg::TIMING_FLAG_BIT];
  assign qidx     = 4'(step_q - 5'd1);

  // Index of the final cycle of each command sequence
  function automatic logic [4:0] seq_last(input fbcd_pkg::fbcd_op_type op);
    case (op)
      fbcd_pkg::OP_IDENT:       seq_last = 5'd2;
      fbcd_pkg::OP_SEC_ENTER:   seq_last = 5'd2;
      fbcd_pkg::OP_SEC_EXIT:    seq_last = 5'd3;
      fbcd_pkg::OP_QUERY_CHECK: seq_last = fbcd_pkg::QRY_LAST_STEP;
      default:                  seq_last = 5'd0;
    endcase
  endfunction

  // Address and data of one cycle of a sequence
  function automatic fbcd_pkg::fbcd_cyc_type seq_cycle(
      input fbcd_pkg::fbcd_op_type op, input logic [4:0] step,
      input logic [20:0] a, input logic [1:0] sel, input logic bm);
    fbcd_pkg::fbcd_cyc_type c;
    logic [7:0]             ofs;
    c   = '{wr: 1'b1, addr: {a[20:11], fbcd_pkg::UNLOCK1_ADDR}, a_m1: 1'b0,
            data: fbcd_pkg::UNLOCK1_DATA};
    ofs = (sel == 2'd0) ? fbcd_pkg::ID_MFR_OFS :
          (sel == 2'd1) ? fbcd_pkg::ID_DEV_OFS : fbcd_pkg::ID_PROT_OFS;
    if (step == 5'd1 && op != fbcd_pkg::OP_QUERY_CHECK) begin
      c.addr = {a[20:11], fbcd_pkg::UNLOCK2_ADDR};
      c.a_m1 = bm;  // Byte address 555h is word 2AAh with lsb set
      c.data = fbcd_pkg::UNLOCK2_DATA;
    end
    case (op)
      fbcd_pkg::OP_READ: begin
        // No command needed: banks read array, or suspended read, by themselves
        c = '{wr: 1'b0, addr: a, a_m1: 1'b0, data: 8'h00};
      end
      fbcd_pkg::OP_ID_READ: begin
        c = '{wr: 1'b0, addr: {a[20:8], ofs}, a_m1: 1'b0, data: 8'h00};
      end
      fbcd_pkg::OP_RESET: begin
        c.data = fbcd_pkg::CMD_RESET;
      end
      fbcd_pkg::OP_IDENT: begin
        if (step == 5'd2) begin
          c.data = fbcd_pkg::CMD_IDENT;
        end
      end
      fbcd_pkg::OP_QUERY_CHECK: begin
        if (step == 5'd0) begin
          c.addr = {a[20:11], fbcd_pkg::QUERY_ADDR};
          c.data = fbcd_pkg::CMD_QUERY;
        end else if (step == fbcd_pkg::QRY_LAST_STEP) begin
          c.data = fbcd_pkg::CMD_RESET;
        end else begin
          c = '{wr: 1'b0, addr: {a[20:8], 8'(fbcd_pkg::QRY_BASE + {4'h0, 4'(step - 5'd1)})},
                a_m1: 1'b0, data: 8'h00};
        end
      end
      fbcd_pkg::OP_SEC_ENTER: begin
        if (step == 5'd2) begin
          c.data = fbcd_pkg::CMD_SEC_ENTER;
        end
      end
      fbcd_pkg::OP_SEC_EXIT: begin
        if (step == 5'd2) begin
          c.data = fbcd_pkg::CMD_IDENT;
        end else if (step == 5'd3) begin
          c.data = fbcd_pkg::CMD_SEC_EXIT2;
        end
      end
      default: c.wr = 1'b1;
    endcase
    return c;
  endfunction

  // Sequencer; a sequence is always issued whole and back to back
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_q     <= S_IDLE;
      op_q        <= fbcd_pkg::OP_READ;
      req_q       <= '0;
      step_q      <= 5'd0;
      cnt_q       <= 8'h00;
      addr_q      <= 21'h000000;
      sel_q       <= 2'd0;
      bank_q      <= 1'b0;
      busy_q      <= 1'b0;
      start_q     <= 1'b0;
      flash_rst_n <= 1'b1;
      cmd_ready   <= 1'b1;
      rsp_valid   <= 1'b0;
      rsp_err     <= 1'b0;
    end else begin
      start_q   <= 1'b0;
      rsp_valid <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (accept) begin
            op_q   <= cmd_op;
            addr_q <= cmd_addr;
            sel_q  <= cmd_sel;
            bank_q <= cmd_bank;
            busy_q <= bank_busy[cmd_bank];
            step_q <= 5'd0;
            if (refuse) begin
              rsp_valid <= 1'b1;
              rsp_err   <= 1'b1;
            end else if (cmd_op == fbcd_pkg::OP_HW_RESET) begin
              flash_rst_n <= 1'b0;
              cnt_q       <= fbcd_pkg::RP_CYC;
              cmd_ready   <= 1'b0;
              state_q     <= S_HWRST;
            end else begin
              cmd_ready <= 1'b0;
              state_q   <= S_RUN;
            end
          end
        end
        S_RUN: begin
          req_q   <= seq_cycle(op_q, step_q, addr_q, sel_q, byte_mode);
          start_q <= 1'b1;
          state_q <= S_WAIT;
        end
        S_WAIT: begin
          if (cyc_done) begin
            if (auto_rst) begin
              // Timing limit seen on a busy bank: follow with a reset write
              op_q    <= fbcd_pkg::OP_RESET;
              step_q  <= 5'd0;
              state_q <= S_RUN;
            end else if (last) begin
              rsp_valid <= 1'b1;
              rsp_err   <= 1'b0;
              cmd_ready <= 1'b1;
              state_q   <= S_IDLE;
            end else begin
              step_q  <= step_q + 5'd1;
              state_q <= S_RUN;
            end
          end
        end
        S_HWRST: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01 && !flash_rst_n) begin
            flash_rst_n <= 1'b1;
            cnt_q       <= fbcd_pkg::RH_CYC;
          end else if (cnt_q == 8'h01) begin
            rsp_valid <= 1'b1;
            rsp_err   <= 1'b0;
            cmd_ready <= 1'b1;
            state_q   <= S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Read data and query table check
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rsp_data   <= 16'h0000;
      query_fail <= 1'b0;
    end else if (accept && cmd_op == fbcd_pkg::OP_QUERY_CHECK) begin
      query_fail <= 1'b0;
    end else if (state_q == S_WAIT && cyc_done && !req_q.wr) begin
      rsp_data <= cyc_rd;
      if (op_q == fbcd_pkg::OP_QUERY_CHECK && !fbcd_pkg::qry_ok(qidx, cyc_rd, byte_mode)) begin
        query_fail <= 1'b1;
      end
    end
  end

  // Identify tracked per bank, secured mode for both; a reset op ends identify on every bank
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bank_ident   <= 2'b00;
      secured_mode <= 1'b0;
    end else if (accept && !refuse && cmd_op == fbcd_pkg::OP_HW_RESET) begin
      bank_ident   <= 2'b00;
      secured_mode <= 1'b0;
    end else if (fin) begin
      case (op_q)
        fbcd_pkg::OP_IDENT:     bank_ident[bank_q] <= 1'b1;
        fbcd_pkg::OP_RESET:     bank_ident <= 2'b00;
        fbcd_pkg::OP_SEC_ENTER: secured_mode <= 1'b1;
        fbcd_pkg::OP_SEC_EXIT:  secured_mode <= 1'b0;
        default: bank_ident <= bank_ident;
      endcase
    end
  end

  fbcd_cycle u_cycle (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .start     (start_q),
    .req       (req_q),
    .byte_mode (byte_mode),
    .dq_i      (flash_dq_i),
    .pins      (flash_pins),
    .rd_data   (cyc_rd),
    .done      (cyc_done)
  );

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_refuse_busy;
    accept && refuse |=> rsp_valid && rsp_err && cmd_ready && state_q == S_IDLE;
  endproperty
  a_refuse_busy: assert property (p_refuse_busy)
    else $error("Identify to busy flash was not refused");

  property p_hw_reset_low;
    accept && !refuse && cmd_op == fbcd_pkg::OP_HW_RESET |=> !flash_rst_n [*8];
  endproperty
  a_hw_reset_low: assert property (p_hw_reset_low)
    else $error("Reset pin not held low long enough");

  property p_hw_reset_clears;
    $fell(flash_rst_n) |-> !secured_mode && bank_ident == 2'b00;
  endproperty
  a_hw_reset_clears: assert property (p_hw_reset_clears)
    else $error("Mode flags survive reset pin");

  property p_auto_reset;
    state_q == S_WAIT && cyc_done && auto_rst
      |-> ##[1:20] (!flash_pins.we_n && flash_pins.dq_o[7:0] == fbcd_pkg::CMD_RESET);
  endproperty
  a_auto_reset: assert property (p_auto_reset)
    else $error("No reset write after timing limit flag");

  property p_ident_cause;
    $rose(bank_ident[0]) |-> $past(op_q) == fbcd_pkg::OP_IDENT && $past(fin);
  endproperty
  a_ident_cause: assert property (p_ident_cause)
    else $error("Identify flag set without identify sequence");

  property p_reset_clears_ident;
    fin && op_q == fbcd_pkg::OP_RESET |=> bank_ident == 2'b00 && rsp_valid;
  endproperty
  a_reset_clears_ident: assert property (p_reset_clears_ident)
    else $error("Reset write left a bank in identify");

  property p_seq_atomic;
    state_q != S_IDLE |-> !cmd_ready;
  endproperty
  a_seq_atomic: assert property (p_seq_atomic)
    else $error("New command accepted mid sequence");

  c_ident: cover property (fin && op_q == fbcd_pkg::OP_IDENT);
  c_query: cover property (fin && op_q == fbcd_pkg::OP_QUERY_CHECK && !query_fail);
  c_hwrst: cover property ($rose(flash_rst_n));
  c_autorst: cover property (state_q == S_WAIT && cyc_done && auto_rst);

endmodule

`default_nettype wire

/* File: verilog/fbcd_pkg.sv */
// Purpose: Shared constants and types for the host side flash command controller
// Assumes: 100 MHz sys_clk, word address on 21 pins plus a byte-mode lsb pin
// Notes:   Function

package fbcd_pkg;

  // Timing of the pin cycles
  localparam int CLK_NS   = 10;
  localparam int T_WP_NS  = 35;   // Least write strobe low time
  localparam int T_RDA_NS = 70;   // Least read access time
  localparam int T_RP_NS  = 500;  // Least reset pin low time
  localparam int T_RH_NS  = 50;   // Least wait after reset pin release
  localparam logic [7:0] WP_CYC  = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RDA_CYC = 8'((T_RDA_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RP_CYC  = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RH_CYC  = 8'((T_RH_NS + CLK_NS - 1) / CLK_NS);

  // Command addresses (low word address bits) and data
  localparam logic [10:0] UNLOCK1_ADDR  = 11'h555;
  localparam logic [10:0] UNLOCK2_ADDR  = 11'h2aa;
  localparam logic [10:0] QUERY_ADDR    = 11'h055;
  localparam logic [7:0]  UNLOCK1_DATA  = 8'haa;
  localparam logic [7:0]  UNLOCK2_DATA  = 8'h55;
  localparam logic [7:0]  CMD_IDENT     = 8'h90;
  localparam logic [7:0]  CMD_RESET     = 8'hf0;
  localparam logic [7:0]  CMD_QUERY     = 8'h98;
  localparam logic [7:0]  CMD_SEC_ENTER = 8'h88;
  localparam logic [7:0]  CMD_SEC_EXIT2 = 8'h00;

  // Identify word offsets; byte mode doubles them, which lands on the same word
  localparam logic [7:0] ID_MFR_OFS  = 8'h00;
  localparam logic [7:0] ID_DEV_OFS  = 8'h01;
  localparam logic [7:0] ID_PROT_OFS = 8'h02;
  localparam int         TIMING_FLAG_BIT = 5;

  // Extended query window and step layout of the query check
  localparam logic [7:0] QRY_BASE     = 8'h40;
  localparam logic [3:0] QRY_SIM_IDX  = 4'ha;   // Word 4Ah
  localparam logic [3:0] QRY_BOOT_IDX = 4'hf;   // Word 4Fh
  localparam logic [7:0] BOOT_BOTTOM  = 8'h02;
  localparam logic [7:0] BOOT_TOP     = 8'h03;
  localparam logic [4:0] QRY_LAST_STEP = 5'd17;

  typedef enum logic [2:0] {
    OP_READ        = 3'h0,
    OP_ID_READ     = 3'h1,
    OP_RESET       = 3'h2,
    OP_IDENT       = 3'h3,
    OP_QUERY_CHECK = 3'h4,
    OP_SEC_ENTER   = 3'h5,
    OP_SEC_EXIT    = 3'h6,
    OP_HW_RESET    = 3'h7
  } fbcd_op_type;

  // Flash side pins as driven by the controller
  typedef struct packed {
    logic [20:0] addr;
    logic        a_m1;
    logic [15:0] dq_o;
    logic        dq_oe;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
  } fbcd_pins_type;

  // One bus cycle request
  typedef struct packed {
    logic        wr;
    logic [20:0] addr;
    logic        a_m1;
    logic [7:0]  data;
  } fbcd_cyc_type;

  // Expected low byte of extended query word QRY_BASE+idx
  function automatic logic qry_ok(input logic [3:0] idx, input logic [15:0] d,
                                  input logic byte_mode);
    logic       hi_ok;
    logic [7:0] lo;
    hi_ok = byte_mode || (d[15:8] == 8'h00);
    lo    = d[7:0];
    case (idx)
      4'h0: qry_ok = hi_ok && (lo == 8'h50);
      4'h1: qry_ok = hi_ok && (lo == 8'h52);
      4'h2: qry_ok = hi_ok && (lo == 8'h49);
      4'h3: qry_ok = hi_ok && (lo == 8'h31);
      4'h4: qry_ok = hi_ok && (lo == 8'h33);
      4'h5: qry_ok = hi_ok && (lo == 8'h04);
      4'h6: qry_ok = hi_ok && (lo == 8'h02);
      4'h7: qry_ok = hi_ok && (lo == 8'h01);
      4'h8: qry_ok = hi_ok && (lo == 8'h01);
      4'h9: qry_ok = hi_ok && (lo == 8'h04);
      4'ha: qry_ok = hi_ok && (lo != 8'h00);
      4'hb: qry_ok = hi_ok && (lo == 8'h00);
      4'hc: qry_ok = hi_ok && (lo == 8'h00);
      4'hd: qry_ok = hi_ok && (lo == 8'h85);
      4'he: qry_ok = hi_ok && (lo == 8'h95);
      default: qry_ok = hi_ok && ((lo == BOOT_BOTTOM) || (lo == BOOT_TOP));
    endcase
  endfunction

endpackage
